//--- threshold_pkg.sv
package threshold_pkg;

	// channel count and widths
	localparam int NUM_CH = 4;
	localparam int SAMPLE_W = 14;
	localparam int MAG_W = 13;
	localparam int DWELL_W = 16;
	localparam int ADDR_W = 16;
	localparam int CTRL_W = 2;
	localparam int WORD_W = SAMPLE_W + CTRL_W;

	// register offsets
	localparam logic [15:0] ADDR_STATUS = 16'h0040;
	localparam logic [15:0] ADDR_UPPER_LO = 16'h0247;
	localparam logic [15:0] ADDR_UPPER_HI = 16'h0248;
	localparam logic [15:0] ADDR_LOWER_LO = 16'h0249;
	localparam logic [15:0] ADDR_LOWER_HI = 16'h024a;
	localparam logic [15:0] ADDR_DWELL_LO = 16'h024b;
	localparam logic [15:0] ADDR_DWELL_HI = 16'h024c;

	// field positions
	localparam int STATUS_FLAG_LSB = 0;
	localparam int STATUS_CTRL_LSB = 4;
	localparam int STATUS_CTRL_W = 4;
	localparam int THR_HI_W = MAG_W - 8;
	localparam int OVR_CTRL_BIT = CTRL_W - 1;

	// reset values
	localparam logic [12:0] UPPER_RST = 13'h1fff;
	localparam logic [12:0] LOWER_RST = 13'h0000;
	localparam logic [15:0] DWELL_RST = 16'h0001;
	localparam logic [3:0] STATUS_CTRL_RST = 4'h0;

	// timing counts, in sample clock cycles
	localparam int UPPER_MAX_LAT_CYC = 30;
	localparam int LOWER_LAT_CYC = 8;
	localparam int DATA_LAT_CYC = 10;

	// threshold configuration for one channel
	typedef struct packed {
		logic [MAG_W-1:0] upper;
		logic [MAG_W-1:0] lower;
		logic [DWELL_W-1:0] dwell;
	} detect_cfg_t;

	// outgoing link sample: data above control bits
	typedef struct packed {
		logic [SAMPLE_W-1:0] data;
		logic [CTRL_W-1:0] ctrl;
	} link_word_t;

endpackage

//--- threshold_channel.sv
`timescale 1ns/1ps
`default_nettype none

module threshold_channel #(
	parameter int LOWER_LAT = threshold_pkg::LOWER_LAT_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// sample and configuration
	input wire logic [threshold_pkg::SAMPLE_W-1:0] sample_i,
	input wire threshold_pkg::detect_cfg_t cfg_i,
	// flag
	output logic flag_o
);

	typedef enum logic {FLAG_CLEAR, FLAG_SET} flag_state_t;

	// magnitude of a two's complement sample, saturated to the threshold scale
	function automatic logic [threshold_pkg::MAG_W-1:0] abs_sat(
		input logic [threshold_pkg::SAMPLE_W-1:0] s);
		logic [threshold_pkg::SAMPLE_W-1:0] a;
		a = s[threshold_pkg::SAMPLE_W-1] ? (~s + 14'h0001) : s;
		abs_sat = a[threshold_pkg::SAMPLE_W-1] ? 13'h1fff : a[threshold_pkg::MAG_W-1:0];
	endfunction

	logic [threshold_pkg::MAG_W-1:0] mag_reg;
	logic [threshold_pkg::MAG_W-1:0] dly_reg [LOWER_LAT];
	logic [threshold_pkg::DWELL_W-1:0] cnt_reg;
	flag_state_t state_reg;
	logic flag_reg;
	logic hit_upper;
	logic below_lower;

	// fast magnitude stage
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mag_reg <= 13'h0000;
		end else begin
			mag_reg <= abs_sat(sample_i);
		end
	end

	// lower comparison sees the magnitude after the full pipeline delay
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < LOWER_LAT; i++) begin
				dly_reg[i] <= 13'h0000;
			end
		end else begin
			dly_reg[0] <= mag_reg;
			for (int i = 1; i < LOWER_LAT; i++) begin
				dly_reg[i] <= dly_reg[i-1];
			end
		end
	end

	assign hit_upper = mag_reg > cfg_i.upper;
	assign below_lower = dly_reg[LOWER_LAT-1] < cfg_i.lower;

	// flag and dwell counter
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_reg <= FLAG_CLEAR;
			flag_reg <= 1'b0;
			cnt_reg <= 16'h0000;
		end else begin
			case (state_reg)
				FLAG_CLEAR: begin
					cnt_reg <= 16'h0000;
					if (hit_upper) begin
						state_reg <= FLAG_SET;
						flag_reg <= 1'b1;
					end
				end
				FLAG_SET: begin
					if (hit_upper) begin
						cnt_reg <= 16'h0000;
					end else if (below_lower) begin
						if (cnt_reg >= cfg_i.dwell) begin
							state_reg <= FLAG_CLEAR;
							flag_reg <= 1'b0;
							cnt_reg <= 16'h0000;
						end else begin
							cnt_reg <= cnt_reg + 16'h0001;
						end
					end else begin
						cnt_reg <= 16'h0000;
					end
				end
				default: begin
					state_reg <= FLAG_CLEAR;
					flag_reg <= 1'b0;
					cnt_reg <= 16'h0000;
				end
			endcase
		end
	end

	assign flag_o = flag_reg;

endmodule

`default_nettype wire

//--- threshold_detect.sv
// Operation
// - four channels, each with own detect pin
// - upper crossing sets flag at once
// - clear after dwell-exceeding run below lower
// - flags readable as status bits at 0x40
// - upper threshold from two registers, output magnitude
// - upper crossing reaches pin within 30 cycles
// - thirteen-bit lower threshold across two registers
// - lower compare full resolution, pipeline delayed
// - dwell count 1..65535 in two registers
// - overrange follows input, sample-aligned latency
// - overrange as link control bit when enabled
`timescale 1ns/1ps
`default_nettype none

module threshold_detect #(
	parameter int LOWER_LAT = threshold_pkg::LOWER_LAT_CYC,
	parameter int DATA_LAT = threshold_pkg::DATA_LAT_CYC
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// converter samples and overrange, one per channel
	input wire logic [threshold_pkg::NUM_CH-1:0][threshold_pkg::SAMPLE_W-1:0] sample_i,
	input wire logic [threshold_pkg::NUM_CH-1:0] overrange_i,
	// link framing setting
	input wire logic [1:0] control_bits_per_sample_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [threshold_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// link samples
	output threshold_pkg::link_word_t [threshold_pkg::NUM_CH-1:0] link_word_o,
	// fast detect pins
	output logic threshold_out_ch0,
	output logic threshold_out_ch1,
	output logic threshold_out_ch2,
	output logic threshold_out_ch3
);

	localparam int NCH = threshold_pkg::NUM_CH;

	logic [7:0] upper_lo_reg;
	logic [threshold_pkg::THR_HI_W-1:0] upper_hi_reg;
	logic [7:0] lower_lo_reg;
	logic [threshold_pkg::THR_HI_W-1:0] lower_hi_reg;
	logic [7:0] dwell_lo_reg;
	logic [7:0] dwell_hi_reg;
	logic [threshold_pkg::STATUS_CTRL_W-1:0] status_ctrl_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;
	logic [NCH-1:0][threshold_pkg::SAMPLE_W-1:0] sample_reg;
	logic [NCH-1:0] ovr_reg;
	logic [NCH-1:0][threshold_pkg::SAMPLE_W-1:0] data_dly_reg [DATA_LAT];
	logic [NCH-1:0] ovr_dly_reg [DATA_LAT];
	threshold_pkg::link_word_t [NCH-1:0] word_reg;
	logic [NCH-1:0] flag;
	logic [NCH-1:0] pin_reg;
	threshold_pkg::detect_cfg_t cfg;

	// register writes; high bytes keep only the bits the fields use
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			upper_lo_reg <= threshold_pkg::UPPER_RST[7:0];
			upper_hi_reg <= threshold_pkg::UPPER_RST[12:8];
			lower_lo_reg <= threshold_pkg::LOWER_RST[7:0];
			lower_hi_reg <= threshold_pkg::LOWER_RST[12:8];
			dwell_lo_reg <= threshold_pkg::DWELL_RST[7:0];
			dwell_hi_reg <= threshold_pkg::DWELL_RST[15:8];
			status_ctrl_reg <= threshold_pkg::STATUS_CTRL_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				threshold_pkg::ADDR_STATUS: begin
					status_ctrl_reg <= reg_wdata_i[threshold_pkg::STATUS_CTRL_LSB +:
						threshold_pkg::STATUS_CTRL_W];
				end
				threshold_pkg::ADDR_UPPER_LO: begin
					upper_lo_reg <= reg_wdata_i;
				end
				threshold_pkg::ADDR_UPPER_HI: begin
					upper_hi_reg <= reg_wdata_i[threshold_pkg::THR_HI_W-1:0];
				end
				threshold_pkg::ADDR_LOWER_LO: begin
					lower_lo_reg <= reg_wdata_i;
				end
				threshold_pkg::ADDR_LOWER_HI: begin
					lower_hi_reg <= reg_wdata_i[threshold_pkg::THR_HI_W-1:0];
				end
				threshold_pkg::ADDR_DWELL_LO: begin
					dwell_lo_reg <= reg_wdata_i;
				end
				threshold_pkg::ADDR_DWELL_HI: begin
					dwell_hi_reg <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end

	// assembled configuration shared by all channels
	assign cfg.upper = {upper_hi_reg, upper_lo_reg};
	assign cfg.lower = {lower_hi_reg, lower_lo_reg};
	assign cfg.dwell = {dwell_hi_reg, dwell_lo_reg};

	// register reads answer one cycle later; unmapped addresses read zero
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_rd_i;
			if (reg_rd_i) begin
				case (reg_addr_i)
					threshold_pkg::ADDR_STATUS: begin
						rdata_reg <= {status_ctrl_reg, pin_reg};
					end
					threshold_pkg::ADDR_UPPER_LO: begin
						rdata_reg <= upper_lo_reg;
					end
					threshold_pkg::ADDR_UPPER_HI: begin
						rdata_reg <= {3'h0, upper_hi_reg};
					end
					threshold_pkg::ADDR_LOWER_LO: begin
						rdata_reg <= lower_lo_reg;
					end
					threshold_pkg::ADDR_LOWER_HI: begin
						rdata_reg <= {3'h0, lower_hi_reg};
					end
					threshold_pkg::ADDR_DWELL_LO: begin
						rdata_reg <= dwell_lo_reg;
					end
					threshold_pkg::ADDR_DWELL_HI: begin
						rdata_reg <= dwell_hi_reg;
					end
					default: begin
						rdata_reg <= 8'h00;
					end
				endcase
			end
		end
	end

	// input capture of samples and overrange
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sample_reg <= '0;
			ovr_reg <= '0;
		end else begin
			sample_reg <= sample_i;
			ovr_reg <= overrange_i;
		end
	end

	// one detector per channel
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		threshold_channel #(
			.LOWER_LAT(LOWER_LAT)
		) u_chan (
			.ref_clk_i(ref_clk_i),
			.nrst_i(nrst_i),
			.sample_i(sample_reg[c]),
			.cfg_i(cfg),
			.flag_o(flag[c])
		);
	end

	// pin stage: input reg, magnitude, flag, pin = 4 cycles
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_reg <= '0;
		end else begin
			pin_reg <= flag;
		end
	end

	// sample and overrange delayed together so their latency matches
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < DATA_LAT; i++) begin
				data_dly_reg[i] <= '0;
				ovr_dly_reg[i] <= '0;
			end
		end else begin
			data_dly_reg[0] <= sample_reg;
			ovr_dly_reg[0] <= ovr_reg;
			for (int i = 1; i < DATA_LAT; i++) begin
				data_dly_reg[i] <= data_dly_reg[i-1];
				ovr_dly_reg[i] <= ovr_dly_reg[i-1];
			end
		end
	end

	// link word: overrange in the top control bit when control bits are on
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			word_reg <= '0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				word_reg[c].data <= data_dly_reg[DATA_LAT-1][c];
				word_reg[c].ctrl <= '0;
				if (control_bits_per_sample_i != 2'h0) begin
					word_reg[c].ctrl[threshold_pkg::OVR_CTRL_BIT] <=
						ovr_dly_reg[DATA_LAT-1][c];
				end
			end
		end
	end

	// outputs
	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;
	assign link_word_o = word_reg;
	assign threshold_out_ch0 = pin_reg[0];
	assign threshold_out_ch1 = pin_reg[1];
	assign threshold_out_ch2 = pin_reg[2];
	assign threshold_out_ch3 = pin_reg[3];

endmodule

`default_nettype wire

//--- threshold_detect_chk.sv
`timescale 1ns/1ps
`default_nettype none
module threshold_detect_chk #(
	parameter int LOWER_LAT = 8,
	parameter int DATA_LAT = 10
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// inputs of the block
	input wire logic [3:0][13:0] sample_i,
	input wire logic [3:0] overrange_i,
	input wire logic [1:0] control_bits_per_sample_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	// outputs of the block
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire threshold_pkg::link_word_t [3:0] link_word_o,
	input wire logic threshold_out_ch0,
	input wire logic threshold_out_ch1,
	input wire logic threshold_out_ch2,
	input wire logic threshold_out_ch3
);
	logic [3:0] up_cnt;
	logic [12:0] upper_sh;
	logic [3:0] pins;
	logic [1:0] cb;
	logic warm;
	// pin vector, link setting and warm-up flag
	assign pins = {threshold_out_ch3, threshold_out_ch2, threshold_out_ch1, threshold_out_ch0};
	assign cb = control_bits_per_sample_i;
	assign warm = up_cnt == 4'hf;
	// cycles since reset, so history looks never reach into reset
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) up_cnt <= 4'h0;
		else if (!warm) up_cnt <= up_cnt + 4'h1;
	end
	// own copy of the upper threshold bytes
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) upper_sh <= 13'h1fff;
		else if (reg_wr_i && reg_addr_i == 16'h0247) upper_sh[7:0] <= reg_wdata_i;
		else if (reg_wr_i && reg_addr_i == 16'h0248) upper_sh[12:8] <= reg_wdata_i[4:0];
	end
	// sample magnitude, most negative code saturates
	function automatic logic [12:0] mag(input logic [13:0] s);
		logic [13:0] n;
		n = -s;
		if (!s[13]) return s[12:0];
		if (n[13]) return 13'h1fff;
		return n[12:0];
	endfunction
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	chk_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read not answered");
	chk_valid_pulse: assert property (!reg_rd_i |=> !reg_rvalid_o)
		else $error("stray read valid");
	chk_status_mirror: assert property (reg_rd_i && reg_addr_i == 16'h0040
		|=> reg_rdata_o[3:0] == $past(pins)) else $error("status differs from pins");
	chk_ctrl_off: assert property (warm && cb == 2'h0 && $past(cb, DATA_LAT + 2) == 2'h0
		|-> !link_word_o[0].ctrl[1]) else $error("control bit with no control bits");
	chk_ovr_align: assert property (warm && cb != 2'h0 && $past(cb, DATA_LAT + 2) != 2'h0
		|-> link_word_o[0].ctrl[1] == $past(overrange_i[0], DATA_LAT + 2))
		else $error("overrange bit misaligned");
	chk_data_align: assert property (warm
		|-> link_word_o[0].data == $past(sample_i[0], DATA_LAT + 2)) else $error("link data late");
	chk_upper_sets: assert property (warm && mag(sample_i[0]) > upper_sh
		|-> ##[1:30] threshold_out_ch0) else $error("upper crossing not flagged");
	chk_reset_quiet: assert property (up_cnt < 4'h3
		|-> pins == 4'h0 && (!reg_rvalid_o || $past(reg_rd_i)))
		else $error("outputs busy after reset");
endmodule
bind threshold_detect threshold_detect_chk #(.LOWER_LAT(LOWER_LAT), .DATA_LAT(DATA_LAT)) chk (
	.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sample_i(sample_i), .overrange_i(overrange_i),
	.control_bits_per_sample_i(control_bits_per_sample_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .link_word_o(link_word_o),
	.threshold_out_ch0(threshold_out_ch0), .threshold_out_ch1(threshold_out_ch1),
	.threshold_out_ch2(threshold_out_ch2), .threshold_out_ch3(threshold_out_ch3));
`default_nettype wire

//--- gain_watch.sv
`timescale 1ns/1ps
`default_nettype none
module gain_watch (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// fast detect pins and event counts
	input wire logic [3:0] pins_i,
	output logic [3:0][7:0] rises_o
);
	logic [3:0] last_reg;
	// one gain step per rising pin, held level is not a new event
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			last_reg <= 4'h0;
			rises_o <= '0;
		end else begin
			last_reg <= pins_i;
			for (int c = 0; c < 4; c++) begin
				if (pins_i[c] && !last_reg[c]) rises_o[c] <= rises_o[c] + 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [3:0][13:0] sample_i = '0;
	logic [3:0] overrange_i = 4'h0;
	logic [1:0] cbps = 2'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0;
	logic [7:0] reg_wdata_i = 8'h0;
	logic [7:0] reg_rdata_o;
	logic reg_rvalid_o;
	threshold_pkg::link_word_t [3:0] link_word_o;
	wire [3:0] pins;
	logic [3:0][7:0] rises;
	logic [7:0] rd_val;
	int fails = 0;
	int check_count = 0;
	// register rows: write flag, offset, data, expected read
	logic [32:0] rows [15] = '{
		{1'b0, 16'h0247, 8'h00, 8'hff}, {1'b0, 16'h0248, 8'h00, 8'h1f},
		{1'b0, 16'h0249, 8'h00, 8'h00}, {1'b0, 16'h024a, 8'h00, 8'h00},
		{1'b0, 16'h024b, 8'h00, 8'h01}, {1'b0, 16'h024c, 8'h00, 8'h00},
		{1'b0, 16'h0040, 8'h00, 8'h00}, {1'b1, 16'h0247, 8'ha5, 8'ha5},
		{1'b1, 16'h0248, 8'hff, 8'h1f}, {1'b1, 16'h0249, 8'h3c, 8'h3c},
		{1'b1, 16'h024a, 8'hff, 8'h1f}, {1'b1, 16'h024b, 8'h34, 8'h34},
		{1'b1, 16'h024c, 8'h12, 8'h12}, {1'b1, 16'h0040, 8'hf7, 8'hf0},
		{1'b1, 16'h0123, 8'h55, 8'h00}};
	// 25 MHz sample clock
	always #20 ref_clk_i = ~ref_clk_i;
	threshold_detect dut (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sample_i(sample_i), .overrange_i(overrange_i),
		.control_bits_per_sample_i(cbps), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.reg_rvalid_o(reg_rvalid_o), .link_word_o(link_word_o), .threshold_out_ch0(pins[0]),
		.threshold_out_ch1(pins[1]), .threshold_out_ch2(pins[2]), .threshold_out_ch3(pins[3]));
	gain_watch partner (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .pins_i(pins), .rises_o(rises));
	// comparison and small bus helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		tick(1);
		reg_wr_i = 1'b1;
		reg_addr_i = a;
		reg_wdata_i = d;
		tick(1);
		reg_wr_i = 1'b0;
	endtask
	task automatic reg_rd(input logic [15:0] a);
		tick(1);
		reg_rd_i = 1'b1;
		reg_addr_i = a;
		tick(1);
		reg_rd_i = 1'b0;
		check(32'(reg_rvalid_o), 32'h1);
		rd_val = reg_rdata_o;
	endtask
	task automatic run(input logic [13:0] v, input int n);
		sample_i = {4{v}};
		tick(n);
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		tick(12);
		nrst_i = 1'b1;
		foreach (rows[i]) begin
			if (rows[i][32]) reg_wr(rows[i][31:16], rows[i][15:8]);
			reg_rd(rows[i][31:16]);
			check(32'(rd_val), 32'(rows[i][7:0]));
		end
		// upper 1000, lower 500, dwell 3
		reg_wr(16'h0247, 8'he8);
		reg_wr(16'h0248, 8'h03);
		reg_wr(16'h0249, 8'hf4);
		reg_wr(16'h024a, 8'h01);
		reg_wr(16'h024b, 8'h03);
		reg_wr(16'h024c, 8'h00);
		// just over, negative, saturated, equal
		sample_i = {14'h03e8, 14'h2000, 14'h3c17, 14'h03e9};
		tick(4);
		check(32'(pins), 32'h7);
		tick(8);
		reg_rd(16'h0040);
		check(32'(rd_val), 32'hf7);
		// broken runs below lower, then one run of dwell plus one
		run(14'h0, 3);
		run(14'h0258, 1);
		run(14'h0, 3);
		run(14'h0258, 12);
		check(32'(pins), 32'h7);
		run(14'h0, 4);
		run(14'h0258, 14);
		check(32'(pins), 32'h0);
		check(32'(rises), 32'h00010101);
		// every link framing setting with overrange on channel 0
		for (int cb = 0; cb < 4; cb++) begin
			cbps = 2'(cb);
			sample_i[0] = 14'h0123;
			overrange_i = 4'h1;
			tick(1);
			overrange_i = 4'h0;
			sample_i[0] = 14'h0;
			tick(11);
			check(32'(link_word_o[0]), 32'({14'h0123, cb != 0, 1'b0}));
		end
		// reset in mid-run while flags are up
		run(14'h1fff, 6);
		nrst_i = 1'b0;
		tick(1);
		check(32'(pins), 32'h0);
		nrst_i = 1'b1;
		reg_rd(16'h0247);
		check(32'(rd_val), 32'hff);
		tally_and_finish();
	end
	// watchdog far beyond the under two hundred cycles of the run
	initial begin
		#100000;
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
